//--- hdl/rtc_flags_pkg.sv
// Purpose: Constants for the flags and control register of the clock.
// Assumes: One 100 MHz clock; byte-wide register port.
// Notes:   Times are given in their own unit and converted to cycles here.
package rtc_flags_pkg;
    localparam logic [16:0] FLAGS_ADDR       = 17'h1FFF0;
    localparam int          WDOG_BIT         = 7;
    localparam int          ALARM_BIT        = 6;
    localparam int          PFAIL_BIT        = 5;
    localparam int          OSC_BIT          = 4;
    localparam int          UNUSED_BIT       = 3;
    localparam int          CAL_BIT          = 2;
    localparam int          HOLD_BIT         = 1;
    localparam int          SNAP_BIT         = 0;
    localparam int          CLK_HZ           = 100_000_000;
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          OSC_WAIT_MS      = 5;
    localparam int          OSC_WAIT_CYCLES  = (OSC_WAIT_MS * 1_000_000) / CLK_PERIOD_NS;
    localparam int          CAL_HZ           = 512;
    localparam int          CAL_HALF_CYCLES  = CLK_HZ / (2 * CAL_HZ);
    localparam int          CNT_W            = 20;
endpackage

//--- hdl/cal_wave_if.sv
// Purpose: Carries the calibration square wave request and output.
// Assumes: Single clock domain.
// Notes:   Used between the register top and the wave divider.
`timescale 1ns/1ps
interface cal_wave_if;
    logic enable;
    logic wave;
    modport ctrl (output enable, input wave);
    modport gen  (input enable, output wave);
endinterface

//--- hdl/cal_wave_gen.sv
// Purpose: Divides the clock to a 512 Hz square wave while enabled.
// Assumes: Clock at the package rate.
// Notes:   Wave is low and the phase restarts while disabled.
`timescale 1ns/1ps
module cal_wave_gen
    import rtc_flags_pkg::*;
#(
    parameter int HALF_CYCLES = CAL_HALF_CYCLES
) (
    input wire logic    clk,   // System clock.
    input wire logic    reset, // Asynchronous reset.
    cal_wave_if.gen     cw     // Enable in, wave out.
);
    logic [CNT_W-1:0] cnt_reg;
    logic             wave_reg;
    wire              wrap = (cnt_reg == CNT_W'(HALF_CYCLES - 1));

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_reg  <= '0;
            wave_reg <= 1'b0;
        end else if (!cw.enable) begin
            cnt_reg  <= '0;
            wave_reg <= 1'b0;
        end else begin
            cnt_reg  <= wrap ? '0 : cnt_reg + 1'b1;
            wave_reg <= wrap ? ~wave_reg : wave_reg;
        end
    end

    assign cw.wave = wave_reg;
endmodule

//--- hdl/rtc_flags_control.sv
// Purpose: Flags and control byte of the real time clock.
// Assumes: Host port is synchronous; rd_en/wr_en are one-cycle strobes.
// Notes:   Event inputs are one-cycle pulses from the timer units.
//
// Contract
// - Watchdog expiry sets bit 7; a host read of the byte clears it.
// - Alarm match sets bit 6; a host read of the byte clears it.
// - Power failure sets bit 5; a host read of the byte clears it.
// - Oscillator stop sets bit 4 if not running within 5 ms of power up.
// - Oscillator stop is kept by the device; only a host write of 0 clears it.
// - Calibration bit 2 set drives 512 Hz wave on the interrupt pin.
// - Calibration bit is 0 after every power up.
// - Hold bit 1 set freezes timekeeping register updates from counters.
// - Hold bit falling loads the timekeeping registers into the counters.
// - Clock, alarm, calibration, interrupt and flag writes only while hold is 1.
`timescale 1ns/1ps
module rtc_flags_control
    import rtc_flags_pkg::*;
#(
    parameter int OSC_WAIT = OSC_WAIT_CYCLES,
    parameter int CAL_HALF = CAL_HALF_CYCLES
) (
    input  wire logic        clk,             // 100 MHz clock.
    input  wire logic        reset,           // Power-up reset, async, high.
    input  wire logic [16:0] addr,            // Byte address.
    input  wire logic        rd_en,           // Read strobe, one cycle.
    input  wire logic        wr_en,           // Write strobe, one cycle.
    input  wire logic [7:0]  wr_data,         // Write data.
    input  wire logic        wdog_expired,    // Watchdog reached zero pulse.
    input  wire logic        alarm_match,     // Alarm match pulse.
    input  wire logic        power_fail,      // Supply below threshold pulse.
    input  wire logic        osc_running,     // Oscillator running level.
    input  wire logic        osc_flag_kept,   // Stored flag from backup domain.
    input  wire logic        int_request,     // Normal interrupt level.
    output logic [7:0]       rd_data,         // Read data, valid cycle after strobe.
    output logic             rtc_write_ok,    // Other RTC registers writable.
    output logic             freeze_update,   // Stop counter-to-register updates.
    output logic             load_counters,   // One-cycle load pulse.
    output logic             snapshot,        // One-cycle capture pulse.
    output logic             osc_flag_store,  // Flag value to backup domain.
    output logic             int_out,         // Interrupt pin output level.
    output logic             int_oe_n         // Low while pin is driven.
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire        hit      = (addr == FLAGS_ADDR);
    wire        rd_hit   = rd_en && hit;
    wire        wr_hit   = wr_en && hit;
    logic [7:0] ctrl_reg;
    wire        wr_ok    = wr_hit && ctrl_reg[HOLD_BIT];
    wire        hold_wr  = wr_hit;   // Hold bit must stay writable to open the gate.

    logic wdog_reg, alarm_reg, pfail_reg, osc_reg;
    logic cal_reg, hold_reg, snap_reg;
    logic [CNT_W-1:0] osc_cnt_reg;
    logic osc_check_reg;
    logic [7:0] rd_data_reg;
    logic load_reg, snapshot_reg, int_out_reg, int_oe_n_reg;

    wire [7:0] flags_view = {wdog_reg, alarm_reg, pfail_reg, osc_reg,
                             1'b0, cal_reg, hold_reg, snap_reg};
    assign ctrl_reg = flags_view;

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    // Set wins over a clear in the same cycle so no event is lost.
    wire wdog_next  = wdog_expired | (wdog_reg  & ~rd_hit);
    wire alarm_next = alarm_match  | (alarm_reg & ~rd_hit);
    wire pfail_next = power_fail   | (pfail_reg & ~rd_hit);
    wire osc_timeout = osc_check_reg && (osc_cnt_reg == CNT_W'(OSC_WAIT - 1)) && !osc_running;
    wire osc_next   = osc_timeout | ((wr_ok && !wr_data[OSC_BIT]) ? 1'b0 : osc_reg);
    wire cal_next   = wr_ok ? wr_data[CAL_BIT] : cal_reg;
    wire hold_next  = hold_wr ? wr_data[HOLD_BIT] : hold_reg;
    wire snap_next  = wr_ok ? wr_data[SNAP_BIT] : snap_reg;

    cal_wave_if cw();
    assign cw.enable = cal_reg;

    cal_wave_gen #(
        .HALF_CYCLES (CAL_HALF)
    ) u_wave (
        .clk   (clk),
        .reset (reset),
        .cw    (cw)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wdog_reg  <= 1'b0;
            alarm_reg <= 1'b0;
            pfail_reg <= 1'b0;
            cal_reg   <= 1'b0;
            hold_reg  <= 1'b0;
            snap_reg  <= 1'b0;
        end else begin
            wdog_reg  <= wdog_next;
            alarm_reg <= alarm_next;
            pfail_reg <= pfail_next;
            cal_reg   <= cal_next;
            hold_reg  <= hold_next;
            snap_reg  <= snap_next;
        end
    end

    // The stored flag is restored one cycle after release, never from reset.
    logic restore_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            restore_reg   <= 1'b1;
            osc_reg       <= 1'b0;
            osc_cnt_reg   <= '0;
            osc_check_reg <= 1'b1;
        end else begin
            restore_reg   <= 1'b0;
            osc_reg       <= restore_reg ? (osc_flag_kept | osc_timeout) : osc_next;
            osc_cnt_reg   <= osc_check_reg ? osc_cnt_reg + 1'b1 : osc_cnt_reg;
            if (osc_running || osc_timeout) begin
                osc_check_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_data_reg  <= 8'h00;
            load_reg     <= 1'b0;
            snapshot_reg <= 1'b0;
            int_out_reg  <= 1'b0;
            int_oe_n_reg <= 1'b1;
        end else begin
            rd_data_reg  <= rd_hit ? flags_view : 8'h00;
            load_reg     <= hold_reg & ~hold_next;
            snapshot_reg <= ~snap_reg & snap_next;
            int_out_reg  <= cal_reg ? cw.wave : int_request;
            int_oe_n_reg <= cal_reg ? 1'b0 : ~int_request;
        end
    end

    assign rd_data        = rd_data_reg;
    assign rtc_write_ok   = hold_reg;
    assign freeze_update  = hold_reg;
    assign load_counters  = load_reg;
    assign snapshot       = snapshot_reg;
    assign osc_flag_store = osc_reg;
    assign int_out        = int_out_reg;
    assign int_oe_n       = int_oe_n_reg;
endmodule

//--- testbench/rtc_host_model.sv
// Purpose: Host processor on the byte port of the flags register.
// Assumes: Requests launch 1 ns after a rising edge and are taken at the next one.
// Notes:   Released address and data lines show the inverse of their last value, never a stale copy; strobes go low.
`timescale 1ns/1ps
module rtc_host_model (
    input  wire logic        clk,     // Clock.
    input  wire logic [7:0]  rd_data, // Read data.
    output logic      [16:0] addr,    // Byte address.
    output logic             rd_en,   // Read strobe.
    output logic             wr_en,   // Write strobe.
    output logic      [7:0]  wr_data  // Write data.
);
    initial {addr, rd_en, wr_en, wr_data} = '0;
    // One idle edge first, so a strobe is never lowered and raised in one step.
    task automatic access(input logic w, input logic [16:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        #1;
        {addr, wr_data, wr_en, rd_en} = {a, d, w, !w};
        @(posedge clk);
        #1;
        q = rd_data;
        {addr, wr_data, wr_en, rd_en} = {~a, ~d, 2'b00};
    endtask
endmodule

//--- testbench/rtc_flags_control_monitor.sv
// Purpose: Port assertions for the flags and control byte.
// Assumes: One clock; reset asynchronous, active high.
// Notes:   The calibration state is tracked from accepted host writes.
`timescale 1ns/1ps
module rtc_flags_control_monitor import rtc_flags_pkg::*; #(parameter int OSC_WAIT = OSC_WAIT_CYCLES) (
    input wire logic        clk,            // Clock.
    input wire logic        reset,          // Reset.
    input wire logic [16:0] addr,           // Address.
    input wire logic        rd_en,          // Read strobe.
    input wire logic        wr_en,          // Write strobe.
    input wire logic [7:0]  wr_data,        // Write data.
    input wire logic        wdog_expired,   // Watchdog event.
    input wire logic        int_request,    // Interrupt level.
    input wire logic [7:0]  rd_data,        // Read data.
    input wire logic        freeze_update,  // Hold level.
    input wire logic        load_counters,  // Load pulse.
    input wire logic        snapshot,       // Capture pulse.
    input wire logic        osc_flag_store, // Oscillator flag.
    input wire logic        int_out         // Pin level.
);
    wire  rd_hit = rd_en && addr == FLAGS_ADDR;
    wire  wr_hit = wr_en && addr == FLAGS_ADDR;
    logic cal_q;
    always_ff @(posedge clk or posedge reset)
        if (reset) cal_q <= 1'b0;
        else if (wr_hit && freeze_update) cal_q <= wr_data[CAL_BIT];
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    hold_level_a: assert property (wr_hit |=> freeze_update == $past(wr_data[HOLD_BIT]))
        else $error("hold level does not follow write");
    load_pulse_a: assert property (load_counters == $fell(freeze_update))
        else $error("load pulse not tied to hold release");
    snap_cause_a: assert property (snapshot |-> $past(wr_hit) && $past(freeze_update)
                                   && $past(wr_data[SNAP_BIT]))
        else $error("capture pulse without accepted write");
    bit3_zero_a: assert property (rd_data[UNUSED_BIT] == 1'b0)
        else $error("unused bit reads one");
    wdog_set_a: assert property (wdog_expired ##1 !rd_hit ##1 rd_hit |=> rd_data[WDOG_BIT])
        else $error("watchdog flag not set");
    wdog_clear_a: assert property (rd_hit && !wdog_expired ##1 !wdog_expired
                                   ##1 rd_hit && !wdog_expired |=> !rd_data[WDOG_BIT])
        else $error("watchdog flag not cleared by read");
    osc_kept_a: assert property (osc_flag_store && !(wr_hit && freeze_update && !wr_data[OSC_BIT]) |=> osc_flag_store)
        else $error("oscillator flag lost");
    osc_read_a: assert property (rd_hit |=> rd_data[OSC_BIT] == $past(osc_flag_store))
        else $error("oscillator flag read wrong");
    cal_off_pin_a: assert property (!$past(reset) && !cal_q && !$past(cal_q) |-> int_out == $past(int_request))
        else $error("pin does not follow interrupt");
endmodule
bind rtc_flags_control rtc_flags_control_monitor #(.OSC_WAIT(OSC_WAIT)) u_monitor (.*);

//--- testbench/test_rtc_flags_control.sv
// Purpose: Self-checking bench for the flags and control byte.
// Assumes: The host model drives the byte port; events come from here.
// Notes:   The oscillator wait is cut to 50 cycles and the wave half period to 4 to keep the run short.
`timescale 1ns/1ps
module test_rtc_flags_control;
    import rtc_flags_pkg::*;
    logic        clk, reset, wdog_expired, alarm_match, power_fail, osc_running, osc_flag_kept, int_request;
    logic        rd_en, wr_en, rtc_write_ok, freeze_update, load_counters, snapshot, osc_flag_store, int_out, int_oe_n;
    logic [16:0] addr;
    logic [7:0]  wr_data, rd_data, q;
    int          errors, checks;
    rtc_flags_control #(.OSC_WAIT(50), .CAL_HALF(4)) u_dut (.*);
    rtc_host_model u_host (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        u_host.access(1'b1, FLAGS_ADDR, d, q);
    endtask
    task automatic rd(input logic [7:0] exp);
        u_host.access(1'b0, FLAGS_ADDR, 8'h00, q);
        check(q, exp);
    endtask
    task automatic pulse(input logic [2:0] ev);
        {wdog_expired, alarm_match, power_fail} = ev;
        @(posedge clk);
        #1 {wdog_expired, alarm_match, power_fail} = 3'b000;
    endtask
    task automatic do_reset(input logic run, input logic kept);
        {reset, osc_running, osc_flag_kept} = {1'b1, run, kept};
        repeat (2) @(posedge clk);
        #1 reset = 1'b0;
    endtask
    task automatic print_verdict;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        {wdog_expired, alarm_match, power_fail, int_request} = 4'h0;
        do_reset(1'b1, 1'b0);
        rd(8'h00);
        pulse(3'b111);
        rd(8'hE0);
        rd(8'h00);
        // Calibration and capture bits are refused until hold was already set.
        wr(8'h05);
        rd(8'h00);
        wr(8'h02);
        check({6'h00, rtc_write_ok, freeze_update}, 8'h03);
        int_request = 1'b1;
        wr(8'h0E);
        // The pin registers the calibration bit one edge after the write lands.
        @(posedge clk);
        #1 check({6'h00, int_oe_n, int_out}, 8'h00);
        repeat (4) @(posedge clk);
        #1 check({6'h00, int_oe_n, int_out}, 8'h01);
        rd(8'h06);
        wr(8'h07);
        check({7'h00, snapshot}, 8'h01);
        wr(8'h07);
        check({7'h00, snapshot}, 8'h00);
        wr(8'h02);
        wr(8'h00);
        check({7'h00, load_counters}, 8'h01);
        rd(8'h00);
        check({7'h00, int_out}, 8'h01);
        u_host.access(1'b0, 17'h1FFF1, 8'h00, q);
        check(q, 8'h00);
        int_request = 1'b0;
        do_reset(1'b0, 1'b0);
        repeat (60) @(posedge clk);
        rd(8'h10);
        wr(8'h10);
        rd(8'h10);
        wr(8'h02);
        wr(8'h02);
        rd(8'h02);
        do_reset(1'b1, 1'b1);
        rd(8'h10);
        print_verdict;
    end
endmodule
